// file: hw/cod_pkg.sv
// constants, types and cycle classes for the opcode decode subset
// What this block does
// RULE1 - index-to-stack transfer: stack pointer gets index pair minus one, free then fetch
// RULE2 - wait clears interrupt mask, free then fetch, then halts until interrupt
// RULE3 - free cycle is one bus clock, no bus needed, shown as read
// RULE4 - program fetch reads next consecutive byte, address advances by one
// RULE5 - vector cycles read top page, high byte before low byte
// RULE6 - stack push writes one byte at the stack pointer
// RULE7 - stack pop reads one byte from the stack
// RULE8 - relative target is next address plus signed offset byte
// RULE9 - direct address has upper byte zero, first page only
// RULE10 - bit number zero to seven taken from the opcode
// RULE11 - indexed offset modes add unsigned byte or full word to index pair
// RULE12 - post-increment modes use index pair, then increment it
// RULE13 - stack offset modes add byte or word offset to stack pointer
// RULE14 - software interrupt pushes five bytes, sets mask, loads vector, eleven cycles
// RULE15 - while halted no bus cycles; resume only on interrupt or reset
package cod_pkg;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h00ff;
  localparam logic [15:0] RST_HX = 16'h0000;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_SWI = 16'hfffc;
  localparam logic [7:0] TOP_PAGE = 8'hff;
  localparam logic [7:0] DIRECT_PAGE = 8'h00;
  localparam logic [7:0] OP_IDX_TO_SP = 8'h94;
  localparam logic [7:0] OP_WAIT = 8'h8f;
  localparam logic [7:0] OP_SWI = 8'h83;
  localparam logic [7:0] OP_PULA = 8'h86;
  localparam logic [7:0] OP_PULX = 8'h88;
  localparam logic [7:0] OP_PULH = 8'h8a;
  localparam logic [2:0] BITOP_HI = 3'h0;
  localparam logic [2:0] SWI_LAST_PUSH = 3'h4;
  localparam logic [2:0] SWI_LAST_REFILL = 3'h1;
  localparam logic SYNC_RST = 1'h1;

  typedef enum logic [8:0] {
    S_VECH = 9'h001, S_VECL = 9'h002, S_FETCH = 9'h004, S_FREE = 9'h008,
    S_PUSH = 9'h010, S_REFILL = 9'h020, S_WAITP = 9'h040, S_HALT = 9'h080,
    S_POP = 9'h100
  } cod_state_t;

  typedef enum logic [2:0] {
    CYC_IDLE = 3'h0, CYC_FREE = 3'h1, CYC_PROG = 3'h2, CYC_PUSH = 3'h3,
    CYC_POP = 3'h4, CYC_VEC = 3'h5
  } cod_cyc_t;

  typedef enum logic [3:0] {
    MODE_IMPLIED = 4'h0, MODE_DIR = 4'h1, MODE_REL = 4'h2,
    MODE_IDX_B = 4'h3, MODE_IDX_W = 4'h4, MODE_IXP = 4'h5,
    MODE_IX1P = 4'h6, MODE_STK_B = 4'h7, MODE_STK_W = 4'h8
  } cod_mode_t;
endpackage : cod_pkg

// file: hw/cod_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module cod_sync import cod_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic din,
  output logic dout
);
  logic s1_r, s2_r, s3_r, out_r;
  logic out_nxt;

  // output moves only once stages two and three agree
  always_comb begin
    out_nxt = (s2_r == s3_r) ? s3_r : out_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      s3_r <= SYNC_RST;
      out_r <= SYNC_RST;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign dout = out_r;
endmodule : cod_sync

// file: hw/cod_ea.sv
// effective address former for the operand addressing modes
`timescale 1ns/1ns
module cod_ea import cod_pkg::*; (
  input cod_mode_t mode,
  input wire logic [15:0] pc_next,
  input wire logic [15:0] hx,
  input wire logic [15:0] sp,
  input wire logic [7:0] off8,
  input wire logic [15:0] off16,
  output logic [15:0] ea,
  output logic post_inc
);
  // offsets are unsigned except the branch byte, which sign-extends
  always_comb begin
    post_inc = 1'b0;
    case (mode)
      MODE_DIR: ea = {DIRECT_PAGE, off8}; // RULE9
      MODE_REL: ea = pc_next + {{8{off8[7]}}, off8}; // RULE8
      MODE_IDX_B: ea = hx + {8'h00, off8}; // RULE11
      MODE_IDX_W: ea = hx + off16; // RULE11
      MODE_IXP: begin
        ea = hx; // RULE12
        post_inc = 1'b1;
      end
      MODE_IX1P: begin
        ea = hx + {8'h00, off8}; // RULE12
        post_inc = 1'b1;
      end
      MODE_STK_B: ea = sp + {8'h00, off8}; // RULE13
      MODE_STK_W: ea = sp + off16; // RULE13
      default: ea = hx;
    endcase
  end
endmodule : cod_ea

// file: hw/cod_seq.sv
// instruction sequencer: bus cycle classes, transfer, wait and swi
`timescale 1ns/1ns
module cod_seq import cod_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic irq_pin_b,
  input wire logic [7:0] bus_rdata,
  input wire logic [7:0] acc_val,
  input wire logic [7:0] cond_val,
  input cod_mode_t ea_mode,
  input wire logic [7:0] ea_off8,
  input wire logic [15:0] ea_off16,
  input wire logic ea_go,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_read,
  output logic bus_active,
  output cod_cyc_t bus_kind,
  output logic [15:0] pc,
  output logic [15:0] sp,
  output logic [15:0] hx,
  output logic imask,
  output logic halted,
  output logic [15:0] ea,
  output logic [7:0] bit_mask,
  output logic [7:0] pop_data
);
  cod_state_t st_r, st_nxt;
  cod_cyc_t kind_r, kind_nxt, iss_kind;
  logic [15:0] pc_r, pc_nxt, sp_r, sp_nxt, hx_r, hx_nxt;
  logic [15:0] addr_r, addr_nxt, iss_addr, ea_r, ea_nxt, ea_calc;
  logic [7:0] wdata_r, wdata_nxt, iss_data, bmask_r, bmask_nxt;
  logic [7:0] pop_r, pop_nxt, pull_r, pull_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic imask_r, imask_nxt, swi_r, swi_nxt, wait_r, wait_nxt;
  logic do_fetch, ea_inc, irq_lvl_b;

  //////////////////////////////////////////////////////////////////////////
  // interrupt pin arrives from outside the clock domain
  cod_sync u_irq_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din(irq_pin_b),
    .dout(irq_lvl_b)
  );

  cod_ea u_ea (
    .mode(ea_mode),
    .pc_next(pc_r),
    .hx(hx_r),
    .sp(sp_r),
    .off8(ea_off8),
    .off16(ea_off16),
    .ea(ea_calc),
    .post_inc(ea_inc)
  );

  // byte pushed in each swi stack cycle, low pc first
  function automatic logic [7:0] swi_byte(input logic [2:0] idx,
      input logic [15:0] pcv, input logic [15:0] hxv,
      input logic [7:0] av, input logic [7:0] cv);
    case (idx)
      3'h0: swi_byte = pcv[7:0];
      3'h1: swi_byte = pcv[15:8];
      3'h2: swi_byte = hxv[7:0];
      3'h3: swi_byte = av;
      default: swi_byte = cv;
    endcase
  endfunction : swi_byte

  //////////////////////////////////////////////////////////////////////////
  // next state and next bus cycle; bus fields are registered so each
  // cycle's address and class are decided one clock ahead
  always_comb begin
    st_nxt = st_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    hx_nxt = hx_r;
    imask_nxt = imask_r;
    swi_nxt = swi_r;
    wait_nxt = wait_r;
    cnt_nxt = cnt_r;
    pull_nxt = pull_r;
    pop_nxt = pop_r;
    bmask_nxt = bmask_r;
    ea_nxt = ea_r;
    iss_kind = CYC_IDLE;
    iss_addr = addr_r;
    iss_data = 8'h00;
    do_fetch = 1'b0;
    case (st_r)
      S_VECH: begin
        pc_nxt[15:8] = bus_rdata; // RULE5
        st_nxt = S_VECL;
        iss_kind = CYC_VEC;
        iss_addr = addr_r + 16'h0001;
      end
      S_VECL: begin
        pc_nxt[7:0] = bus_rdata; // RULE5
        if (swi_r) begin
          st_nxt = S_FREE;
          iss_kind = CYC_FREE;
        end else begin
          st_nxt = S_FETCH;
          do_fetch = 1'b1;
        end
      end
      S_FETCH: begin
        if (bus_rdata[7:5] == BITOP_HI) begin
          bmask_nxt = 8'h01 << bus_rdata[3:1]; // RULE10
        end
        if (bus_rdata == OP_IDX_TO_SP) begin
          sp_nxt = hx_r - 16'h0001; // RULE1
          st_nxt = S_FREE;
          iss_kind = CYC_FREE;
        end else if (bus_rdata == OP_WAIT) begin
          imask_nxt = 1'b0; // RULE2
          wait_nxt = 1'b1;
          st_nxt = S_FREE;
          iss_kind = CYC_FREE;
        end else if (bus_rdata == OP_SWI) begin
          swi_nxt = 1'b1; // RULE14
          cnt_nxt = 3'h0;
          st_nxt = S_PUSH;
          iss_kind = CYC_PUSH;
          iss_addr = sp_r;
          iss_data = swi_byte(3'h0, pc_r, hx_r, acc_val, cond_val);
          sp_nxt = sp_r - 16'h0001;
        end else if (bus_rdata == OP_PULA || bus_rdata == OP_PULX ||
                     bus_rdata == OP_PULH) begin
          pull_nxt = bus_rdata;
          sp_nxt = sp_r + 16'h0001;
          st_nxt = S_POP;
          iss_kind = CYC_POP; // RULE7
          iss_addr = sp_nxt;
        end else begin
          do_fetch = 1'b1;
        end
      end
      S_PUSH: begin
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == SWI_LAST_PUSH) begin
          imask_nxt = 1'b1; // RULE14
          st_nxt = S_VECH;
          iss_kind = CYC_VEC;
          iss_addr = VEC_SWI;
        end else begin
          iss_kind = CYC_PUSH; // RULE6
          iss_addr = sp_r;
          iss_data = swi_byte(cnt_nxt, pc_r, hx_r, acc_val, cond_val);
          sp_nxt = sp_r - 16'h0001;
        end
      end
      S_FREE: begin
        if (swi_r) begin
          // queue refill reads do not move pc; the opcode fetch does
          swi_nxt = 1'b0;
          cnt_nxt = 3'h0;
          st_nxt = S_REFILL;
          iss_kind = CYC_PROG;
          iss_addr = pc_r;
        end else if (wait_r) begin
          st_nxt = S_WAITP;
          iss_kind = CYC_PROG; // RULE2
          iss_addr = pc_r;
        end else begin
          st_nxt = S_FETCH;
          do_fetch = 1'b1; // RULE1
        end
      end
      S_REFILL: begin
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == SWI_LAST_REFILL) begin
          st_nxt = S_FETCH;
          do_fetch = 1'b1;
        end else begin
          iss_kind = CYC_PROG;
          iss_addr = pc_r + 16'h0001;
        end
      end
      S_WAITP: begin
        wait_nxt = 1'b0;
        st_nxt = S_HALT;
      end
      S_HALT: begin
        // mask is clear here, so any asserted request wakes the core
        if (!irq_lvl_b && !imask_r) begin
          st_nxt = S_FETCH; // RULE15
          do_fetch = 1'b1;
        end
      end
      S_POP: begin
        if (pull_r == OP_PULX) begin
          hx_nxt[7:0] = bus_rdata;
        end else if (pull_r == OP_PULH) begin
          hx_nxt[15:8] = bus_rdata;
        end else begin
          pop_nxt = bus_rdata;
        end
        st_nxt = S_FREE;
        iss_kind = CYC_FREE;
      end
      default: begin
        st_nxt = S_VECH;
      end
    endcase
    if (do_fetch) begin
      iss_kind = CYC_PROG; // RULE4
      iss_addr = pc_nxt;
      pc_nxt = pc_nxt + 16'h0001;
    end
    if (ea_go) begin
      ea_nxt = ea_calc;
      if (ea_inc) begin
        hx_nxt = hx_nxt + 16'h0001; // RULE12
      end
    end
    kind_nxt = iss_kind;
    addr_nxt = iss_addr;
    wdata_nxt = iss_data;
  end

  // reset starts with the reset vector read on the very first cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= S_VECH;
      kind_r <= CYC_VEC;
      addr_r <= VEC_RESET;
      wdata_r <= 8'h00;
      pc_r <= RST_PC;
      sp_r <= RST_SP;
      hx_r <= RST_HX;
      imask_r <= 1'b1;
      swi_r <= 1'b0;
      wait_r <= 1'b0;
      cnt_r <= 3'h0;
      pull_r <= 8'h00;
      pop_r <= 8'h00;
      bmask_r <= 8'h00;
      ea_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      hx_r <= hx_nxt;
      imask_r <= imask_nxt;
      swi_r <= swi_nxt;
      wait_r <= wait_nxt;
      cnt_r <= cnt_nxt;
      pull_r <= pull_nxt;
      pop_r <= pop_nxt;
      bmask_r <= bmask_nxt;
      ea_r <= ea_nxt;
    end
  end

  // free cycles and idle are shown as reads
  assign bus_addr = addr_r;
  assign bus_wdata = wdata_r;
  assign bus_kind = kind_r;
  assign bus_active = (kind_r != CYC_IDLE);
  assign bus_read = (kind_r != CYC_PUSH); // RULE3
  assign pc = pc_r;
  assign sp = sp_r;
  assign hx = hx_r;
  assign imask = imask_r;
  assign halted = (st_r == S_HALT);
  assign ea = ea_r;
  assign bit_mask = bmask_r;
  assign pop_data = pop_r;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_IDX_TO_SP: assert property ( // RULE1
    st_r == S_FETCH && bus_rdata == OP_IDX_TO_SP |=>
      sp_r == $past(hx_r) - 16'h0001 && kind_r == CYC_FREE
      ##1 kind_r == CYC_PROG)
    else $error("index to stack transfer wrong");
  AST_WAIT_HALT: assert property ( // RULE2
    st_r == S_FETCH && bus_rdata == OP_WAIT |=>
      !imask_r && kind_r == CYC_FREE ##1 kind_r == CYC_PROG ##1 halted)
    else $error("wait sequence wrong");
  AST_FREE_READ: assert property ( // RULE3
    kind_r == CYC_FREE |-> bus_read && bus_active)
    else $error("free cycle not a read");
  AST_FETCH_STEP: assert property ( // RULE4
    st_r == S_FETCH && st_nxt == S_FETCH && kind_nxt == CYC_PROG |=>
      kind_r == CYC_PROG && addr_r == $past(addr_r) + 16'h0001)
    else $error("fetch address did not advance by one");
  AST_VEC_ORDER: assert property ( // RULE5
    kind_r == CYC_VEC && !addr_r[0] |-> addr_r[15:8] == TOP_PAGE
      ##1 kind_r == CYC_VEC && addr_r == $past(addr_r) + 16'h0001)
    else $error("vector order wrong");
  AST_PUSH_WRITE: assert property ( // RULE6
    kind_r == CYC_PUSH |-> !bus_read && addr_r == sp_r + 16'h0001)
    else $error("push not at stack pointer");
  AST_POP_READ: assert property ( // RULE7
    kind_r == CYC_POP |-> bus_read && addr_r == sp_r)
    else $error("pop not at stack");
  AST_DIR_PAGE: assert property ( // RULE9
    ea_go && ea_mode == MODE_DIR |=> ea_r[15:8] == DIRECT_PAGE)
    else $error("direct address left first page");
  AST_BIT_SEL: assert property ( // RULE10
    st_r == S_FETCH && bus_rdata[7:5] == BITOP_HI |=>
      bmask_r == (8'h01 << $past(bus_rdata[3:1])))
    else $error("bit select wrong");
  AST_POST_INC: assert property ( // RULE12
    ea_go && ea_mode == MODE_IXP && st_r != S_POP |=>
      hx_r == $past(hx_r) + 16'h0001 && ea_r == $past(hx_r))
    else $error("post increment wrong");
  AST_SWI_LEN: assert property ( // RULE14
    st_r == S_FETCH && bus_rdata == OP_SWI |=>
      kind_r == CYC_PUSH [*5] ##1 kind_r == CYC_VEC [*2]
      ##1 kind_r == CYC_FREE ##1 kind_r == CYC_PROG [*3] ##0 imask_r)
    else $error("software interrupt sequence wrong");
  AST_HALT_QUIET: assert property ( // RULE15
    halted |-> !bus_active)
    else $error("bus cycle while halted");
endmodule : cod_seq

// file: verif/cod_mem.sv
// zero-wait byte memory standing on the far side of the system bus
`timescale 1ns/1ns
module cod_mem (
  input wire logic clk,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_read,
  input wire logic bus_active,
  output logic [7:0] bus_rdata
);
  logic [7:0] store [65536];
  logic [7:0] last_r = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // answers every read in its own cycle; an idle bus shows the inverted
  // last byte so a sampled idle value never matches by luck
  always_comb begin
    if (bus_active && bus_read) begin
      bus_rdata = store[bus_addr];
    end else begin
      bus_rdata = ~last_r;
    end
  end

  // plain always so the bench may preload the array at time zero
  always @(posedge clk) begin
    if (bus_active && bus_read) begin
      last_r <= store[bus_addr];
    end
    if (bus_active && !bus_read) begin
      store[bus_addr] <= bus_wdata;
    end
  end
endmodule : cod_mem

// file: verif/tb.sv
// self-checking bench for the sequencer against a small program
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb import cod_pkg::*; ;
  logic clk = 1'b0, rst_b = 1'b0, irq_pin_b = 1'b1, ea_go = 1'b0;
  logic [7:0] bus_rdata, bus_wdata, bit_mask, pop_data, ea_off8 = 8'h00;
  logic [15:0] bus_addr, pc, sp, hx, ea, ea_off16 = 16'h0000;
  logic bus_read, bus_active, imask, halted;
  cod_mode_t ea_mode = MODE_IMPLIED;
  cod_cyc_t bus_kind;
  int mismatches = 0, checks_done = 0, tn = 0;
  cod_cyc_t tk [40];
  logic [15:0] ta [40];
  logic tr [40];
  // expected bus trace of the program, free cycles carry no address
  localparam cod_cyc_t EK [32] = '{CYC_VEC, CYC_VEC, CYC_PROG, CYC_FREE,
    CYC_PROG, CYC_POP, CYC_FREE, CYC_PROG, CYC_POP, CYC_FREE, CYC_PROG,
    CYC_FREE, CYC_PROG, CYC_PUSH, CYC_PUSH, CYC_PUSH, CYC_PUSH, CYC_PUSH,
    CYC_VEC, CYC_VEC, CYC_FREE, CYC_PROG, CYC_PROG, CYC_PROG, CYC_FREE,
    CYC_PROG, CYC_PROG, CYC_PROG, CYC_PROG, CYC_PROG, CYC_PROG, CYC_POP};
  localparam logic [15:0] XA [32] = '{16'hfffe, 16'hffff, 16'h0100, 16'h0,
    16'h0101, 16'h0000, 16'h0, 16'h0102, 16'h0001, 16'h0, 16'h0103, 16'h0,
    16'h0104, 16'h1233, 16'h1232, 16'h1231, 16'h1230, 16'h122f, 16'hfffc,
    16'hfffd, 16'h0, 16'h0200, 16'h0201, 16'h0200, 16'h0, 16'h0201,
    16'h0201, 16'h0202, 16'h0203, 16'h0204, 16'h0205, 16'h122f};
  localparam logic [7:0] PB [5] = '{8'h05, 8'h01, 8'h34, 8'ha5, 8'hc3};

  cod_seq dut (.clk(clk), .rst_b(rst_b), .irq_pin_b(irq_pin_b),
    .bus_rdata(bus_rdata), .acc_val(8'ha5), .cond_val(8'hc3),
    .ea_mode(ea_mode), .ea_off8(ea_off8), .ea_off16(ea_off16),
    .ea_go(ea_go), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_read(bus_read), .bus_active(bus_active), .bus_kind(bus_kind),
    .pc(pc), .sp(sp), .hx(hx), .imask(imask), .halted(halted), .ea(ea),
    .bit_mask(bit_mask), .pop_data(pop_data));
  cod_mem mem_model (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_read(bus_read), .bus_active(bus_active), .bus_rdata(bus_rdata));

  initial begin
    forever #20 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  // log each finished bus cycle; values read here are still the old ones
  always @(posedge clk) begin
    if (rst_b && bus_active === 1'b1 && tn < 40) begin
      tk[tn] = bus_kind;
      ta[tn] = bus_addr;
      tr[tn] = bus_read;
      tn++;
    end
  end

  task automatic conclude();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic wait_trace(input int n);
    int k;
    k = 0;
    while (tn < n && k < 400) begin
      @(negedge clk);
      k++;
    end
    if (tn < n) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, tn, n);
      conclude();
    end
  endtask : wait_trace

  task automatic cmp_span(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      `CHK(tk[i], EK[i])
      if (EK[i] != CYC_FREE) `CHK(ta[i], XA[i])
      `CHK(tr[i], EK[i] != CYC_PUSH)
    end
  endtask : cmp_span

  task automatic do_ea(input cod_mode_t m, input logic [7:0] o8,
                       input logic [15:0] o16, input logic [15:0] exp);
    ea_mode = m;
    ea_off8 = o8;
    ea_off16 = o16;
    // strobe stays high between calls; the scenario drops it at the end
    ea_go = 1'b1;
    @(negedge clk);
    `CHK(ea, exp)
  endtask : do_ea

  //////////////////////////////////////////////////////////////////////////
  // scenarios, all but scn_ea judging a stretch of the trace
  task automatic scn_boot();
    wait_trace(3);
    cmp_span(0, 2);
  endtask : scn_boot

  task automatic scn_xfer_pull();
    wait_trace(12);
    `CHK(sp, 16'h1233)
    `CHK(hx, 16'h1234)
    wait_trace(13);
    cmp_span(3, 12);
  endtask : scn_xfer_pull

  task automatic scn_swi();
    wait_trace(20);
    `CHK(imask, 1'b1)
    wait_trace(24);
    cmp_span(13, 23);
    `CHK(sp, 16'h122e)
    for (int i = 0; i < 5; i++) `CHK(mem_model.store[16'h1233 - i], PB[i])
  endtask : scn_swi

  task automatic scn_wait();
    int seen;
    wait_trace(26);
    cmp_span(24, 25);
    repeat (2) @(negedge clk);
    `CHK(halted, 1'b1)
    `CHK(imask, 1'b0)
    `CHK(pc, 16'h0201)
    seen = tn;
    repeat (8) begin
      @(negedge clk);
      `CHK(bus_active, 1'b0)
    end
    `CHK(tn, seen)
  endtask : scn_wait

  // pc 0201 and sp 122e stand still while halted; hx starts at 1234 and the post-increment modes step it to 1236
  task automatic scn_ea();
    do_ea(MODE_DIR, 8'h5a, 16'h0000, 16'h005a);
    do_ea(MODE_REL, 8'hf0, 16'h0000, 16'h01f1);
    do_ea(MODE_REL, 8'h7f, 16'h0000, 16'h0280);
    do_ea(MODE_IDX_B, 8'hff, 16'h0000, 16'h1333);
    do_ea(MODE_IDX_W, 8'h00, 16'h8000, 16'h9234);
    do_ea(MODE_STK_B, 8'h10, 16'h0000, 16'h123e);
    do_ea(MODE_STK_W, 8'h00, 16'h0100, 16'h132e);
    do_ea(MODE_IXP, 8'h00, 16'h0000, 16'h1234);
    do_ea(MODE_IX1P, 8'h02, 16'h0000, 16'h1237);
    ea_go = 1'b0;
    @(negedge clk);
    `CHK(hx, 16'h1236)
  endtask : scn_ea

  task automatic scn_wake();
    int k;
    k = 0;
    irq_pin_b = 1'b0;
    while (halted !== 1'b0 && k < 20) begin
      @(negedge clk);
      k++;
    end
    `CHK(halted, 1'b0)
    irq_pin_b = 1'b1;
    wait_trace(29);
    `CHK(bit_mask, 8'h20)
    wait_trace(32);
    cmp_span(25, 31);
    `CHK(bit_mask, 8'h80)
    `CHK(pop_data, 8'hc3)
  endtask : scn_wake

  //////////////////////////////////////////////////////////////////////////
  // preload program, stack bytes and vectors, then release reset
  initial begin
    for (int i = 0; i < 65536; i++) mem_model.store[i] = 8'h9d;
    mem_model.store[16'hfffe] = 8'h01;
    mem_model.store[16'hffff] = 8'h00;
    mem_model.store[16'hfffc] = 8'h02;
    mem_model.store[16'hfffd] = 8'h00;
    mem_model.store[16'h0000] = 8'h12;
    mem_model.store[16'h0001] = 8'h34;
    mem_model.store[16'h0100] = OP_IDX_TO_SP;
    mem_model.store[16'h0101] = OP_PULH;
    mem_model.store[16'h0102] = OP_PULX;
    mem_model.store[16'h0103] = OP_IDX_TO_SP;
    mem_model.store[16'h0104] = OP_SWI;
    mem_model.store[16'h0200] = OP_WAIT;
    for (int i = 1; i < 4; i++) mem_model.store[16'h0200 + i] = 8'h1a;
    for (int i = 4; i < 7; i++) mem_model.store[16'h0200 + i] = 8'h0f;
    // accumulator pull reads back the condition byte pushed by the swi
    mem_model.store[16'h0205] = OP_PULA;
    repeat (20) @(negedge clk);
    rst_b <= 1'b1;
    scn_boot();
    scn_xfer_pull();
    scn_swi();
    scn_wait();
    scn_ea();
    scn_wake();
    conclude();
  end
endmodule : tb
